// *** logic/dspic_defines.svh ***
`ifndef DSPIC_DEFINES_SVH
`define DSPIC_DEFINES_SVH
// Contract
// - Eleven interrupt sources plus reset, each leading quickly to a service routine.
// - Four active-low request pins: one programmable, two level, one edge.
// - Second serial port pins may become two more requests plus flag in and out.
// - Internal requests: timer, byte DMA, both serial ports, software, power-down.
// - Fixed priority and per-source mask; power-down and reset cannot be masked.
// - Power-down request ignores the mask, eligible whenever interrupts are on.
// - Programmable pin and both alternate requests select level or edge response.
// - Both level request pins are always plain active-low levels, never latched.
// - Edge request pin latches falling edges; software may set or clear it.
// - Reset or context-reset power-up vectors 0000 first, power-down 002c, timer 0028 last.
// - Then programmable request 0004, level one 0008, level zero 000c.
// - Then port one transmit 0010, receive 0014, edge 0018, DMA 001c, port two tx 0020.
// - Port two receive or alternate request zero uses 0024, just above the timer.
// - Routines either nest by priority or run one after another, as configured.
// - Each pending request except power-down is ANDed with its mask bit before priority selection.
// - The highest-priority remaining request is the one chosen for service.
// - One cycle after a mask write no interrupt is taken; DMA carries on.
// - Control register selects nesting and edge or level for three requests.
// - Write-only force and clear register for pending requests; reads give nothing.
// - Twelve-deep stack saves status on entry and restores it on return.
// - Global on and off gate all servicing except context reset, power-down too, whatever the mask.
// - Interrupt servicing is globally enabled straight after reset.

// ****************************************
// Sources, index is priority (0 highest)
// ****************************************
`define DSPIC_NSRC      11
`define DSPIC_SRC_PD    4'h0
`define DSPIC_SRC_PROG  4'h1
`define DSPIC_SRC_LVL1  4'h2
`define DSPIC_SRC_LVL0  4'h3
`define DSPIC_SRC_S0TX  4'h4
`define DSPIC_SRC_S0RX  4'h5
`define DSPIC_SRC_EDGE  4'h6
`define DSPIC_SRC_BYTE_DMA_PORT  4'h7
`define DSPIC_SRC_S1TX  4'h8
`define DSPIC_SRC_S1RX  4'h9
`define DSPIC_SRC_TMR   4'ha
`define DSPIC_SRC_NONE  4'hf

// ****************************************
// Vectors
// ****************************************
`define DSPIC_VEC_RST   16'h0000
`define DSPIC_VEC_PD    16'h002c
`define DSPIC_VEC_PROG  16'h0004
`define DSPIC_VEC_LVL1  16'h0008
`define DSPIC_VEC_LVL0  16'h000c
`define DSPIC_VEC_S0TX  16'h0010
`define DSPIC_VEC_S0RX  16'h0014
`define DSPIC_VEC_EDGE  16'h0018
`define DSPIC_VEC_BYTE_DMA_PORT  16'h001c
`define DSPIC_VEC_S1TX  16'h0020
`define DSPIC_VEC_S1RX  16'h0024
`define DSPIC_VEC_TMR   16'h0028

// ****************************************
// Registers
// ****************************************
`define DSPIC_OFF_MASK  8'h00
`define DSPIC_OFF_CTRL  8'h04
`define DSPIC_OFF_IFC   8'h08
`define DSPIC_OFF_STAT  8'h0c
`define DSPIC_OFF_VEC   8'h10
`define DSPIC_CTL_E2    0
`define DSPIC_CTL_E1    1
`define DSPIC_CTL_E0    2
`define DSPIC_CTL_NEST  3
`define DSPIC_CTL_ALT   4
`define DSPIC_CTL_FOUT  5
`define DSPIC_CTL_W     6
`define DSPIC_IFC_CLR   16
`define DSPIC_STAT_ISR  16
`define DSPIC_STAT_GIE  27
`define DSPIC_STAT_OVF  28
`define DSPIC_MASK_RST  11'h000
`define DSPIC_CTRL_RST  6'h00
`define DSPIC_STK_DEPTH 4'hc
`endif

// *** logic/dspic_pkg.sv ***
`include "dspic_defines.svh"
package dspic_pkg;
   typedef logic [`DSPIC_NSRC-1:0] dspic_src_t;

   typedef struct packed {
      logic prog_n;
      logic lvl1_n;
      logic lvl0_n;
      logic edge_n;
      logic alt0_n;
      logic alt1_n;
      logic flag_in;
   } dspic_pins_t;

   typedef struct packed {
      logic sp0_tx;
      logic sp0_rx;
      logic byte_dma_port;
      logic sp1_tx;
      logic sp1_rx;
      logic timer;
      logic pwrdn;
   } dspic_evt_t;

   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } dspic_bus_t;
endpackage : dspic_pkg

// *** logic/dspic_ctrl.sv ***
`include "dspic_defines.svh"
module dspic_ctrl
   import dspic_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire dspic_bus_t  bus_i,
   output logic [31:0]      rdata_o,
   input  wire dspic_pins_t pins_i,
   input  wire dspic_evt_t  evt_i,
   input  wire logic        powerup_i,
   input  wire logic        powerup_context_reset_bit_i,
   input  wire logic        ack_i,
   input  wire logic        rti_i,
   input  wire logic        global_irq_on_instr_i,
   input  wire logic        global_irq_off_instr_i,
   input  wire logic        stk_push_i,
   input  wire logic        stk_pop_i,
   input  wire logic [15:0] status_i,
   output logic             irq_req_o,
   output logic [15:0]      irq_vec_o,
   output logic [3:0]       irq_src_o,
   output logic [15:0]      stk_top_o,
   output logic             stk_full_o,
   output logic             stk_empty_o,
   output logic             flag_in_o,
   output logic             flag_out_o,
   output logic             sp1_alt_o
);

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [3:0] dspic_first(input dspic_src_t v);
      logic [3:0] r;
      r = `DSPIC_SRC_NONE;
      for (int i = `DSPIC_NSRC - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = 4'(i);
         end
      end
      return r;
   endfunction : dspic_first

   function automatic logic [15:0] dspic_vec_of(input logic [3:0] s);
      logic [15:0] v;
      v = `DSPIC_VEC_TMR;
      unique case (s)
         `DSPIC_SRC_PD:   v = `DSPIC_VEC_PD;
         `DSPIC_SRC_PROG: v = `DSPIC_VEC_PROG;
         `DSPIC_SRC_LVL1: v = `DSPIC_VEC_LVL1;
         `DSPIC_SRC_LVL0: v = `DSPIC_VEC_LVL0;
         `DSPIC_SRC_S0TX: v = `DSPIC_VEC_S0TX;
         `DSPIC_SRC_S0RX: v = `DSPIC_VEC_S0RX;
         `DSPIC_SRC_EDGE: v = `DSPIC_VEC_EDGE;
         `DSPIC_SRC_BYTE_DMA_PORT: v = `DSPIC_VEC_BYTE_DMA_PORT;
         `DSPIC_SRC_S1TX: v = `DSPIC_VEC_S1TX;
         `DSPIC_SRC_S1RX: v = `DSPIC_VEC_S1RX;
         default:         v = `DSPIC_VEC_TMR;
      endcase
      return v;
   endfunction : dspic_vec_of

   // ****************************************
   // State
   // ****************************************
   dspic_pins_t             sync1_r;
   dspic_pins_t             sync2_r;
   dspic_pins_t             sync3_r;
   dspic_src_t              pend_r;
   dspic_src_t              isr_r;
   logic [`DSPIC_NSRC-1:0]  mask_r;
   logic [`DSPIC_CTL_W-1:0] ctrl_r;
   logic                    gie_r;
   logic                    holdoff_r;
   logic                    rstreq_r;
   logic                    req_r;
   logic                    rst_sel_r;
   logic [3:0]              idx_r;
   logic [15:0]             vec_r;
   logic [15:0]             stk_mem [`DSPIC_STK_DEPTH];
   logic [3:0]              sp_r;
   logic [15:0]             stk_top_r;
   logic                    stk_ovf_r;
   logic [31:0]             rdata_r;

   dspic_pins_t act_w;
   dspic_pins_t fall_w;
   dspic_src_t  set_w;
   dspic_src_t  lvl_w;
   dspic_src_t  force_w;
   dspic_src_t  clr_w;
   dspic_src_t  ackclr_w;
   dspic_src_t  req_w;
   dspic_src_t  mask_eff_w;
   dspic_src_t  elig_w;
   logic [3:0]  sel_w;
   logic [3:0]  isr_top_w;
   logic        allow_w;
   logic        take_w;
   logic        req_nxt;
   logic        ifc_wr_w;
   logic        push_w;
   logic        pop_w;

   // ****************************************
   // Pin synchronisers
   // ****************************************
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync1_r <= '1;
         sync2_r <= '1;
         sync3_r <= '1;
      end else begin
         sync1_r <= pins_i;
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
      end
   end

   // Low-active pins; flag_in is carried but never compared for edges
   assign act_w  = ~sync2_r;
   assign fall_w = sync3_r & ~sync2_r;

   // ****************************************
   // Request sources
   // ****************************************
   always_comb begin
      set_w = '0;
      lvl_w = '0;
      set_w[`DSPIC_SRC_PD]   = evt_i.pwrdn;
      set_w[`DSPIC_SRC_S0TX] = evt_i.sp0_tx;
      set_w[`DSPIC_SRC_S0RX] = evt_i.sp0_rx;
      set_w[`DSPIC_SRC_BYTE_DMA_PORT] = evt_i.byte_dma_port;
      set_w[`DSPIC_SRC_TMR]  = evt_i.timer;
      set_w[`DSPIC_SRC_EDGE] = fall_w.edge_n;
      lvl_w[`DSPIC_SRC_LVL1] = act_w.lvl1_n;
      lvl_w[`DSPIC_SRC_LVL0] = act_w.lvl0_n;
      if (ctrl_r[`DSPIC_CTL_E2]) begin
         set_w[`DSPIC_SRC_PROG] = fall_w.prog_n;
      end else begin
         lvl_w[`DSPIC_SRC_PROG] = act_w.prog_n;
      end
      if (ctrl_r[`DSPIC_CTL_ALT]) begin
         if (ctrl_r[`DSPIC_CTL_E1]) begin
            set_w[`DSPIC_SRC_S1TX] = fall_w.alt1_n;
         end else begin
            lvl_w[`DSPIC_SRC_S1TX] = act_w.alt1_n;
         end
         if (ctrl_r[`DSPIC_CTL_E0]) begin
            set_w[`DSPIC_SRC_S1RX] = fall_w.alt0_n;
         end else begin
            lvl_w[`DSPIC_SRC_S1RX] = act_w.alt0_n;
         end
      end else begin
         set_w[`DSPIC_SRC_S1TX] = evt_i.sp1_tx;
         set_w[`DSPIC_SRC_S1RX] = evt_i.sp1_rx;
      end
   end

   // Software force and clear; the register itself holds nothing
   assign ifc_wr_w = bus_i.wr && (bus_i.addr == `DSPIC_OFF_IFC);
   assign force_w  = ifc_wr_w ? bus_i.wdata[`DSPIC_NSRC-1:0] : '0;
   assign clr_w    = ifc_wr_w ? bus_i.wdata[`DSPIC_IFC_CLR +: `DSPIC_NSRC] : '0;
   assign take_w   = ack_i && req_r;
   assign ackclr_w = (take_w && !rst_sel_r) ? (dspic_src_t'(1) << idx_r) : '0;

   // ****************************************
   // Pending latches
   // ****************************************
   // A new edge in the clearing cycle survives: sets are ORed in last
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pend_r <= '0;
      end else begin
         pend_r <= (pend_r & ~clr_w & ~ackclr_w) | set_w | force_w;
      end
   end

   // Context reset on power-up outranks every source and ignores gating
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rstreq_r <= 1'b0;
      end else if (powerup_i && powerup_context_reset_bit_i) begin
         rstreq_r <= 1'b1;
      end else if (take_w && rst_sel_r) begin
         rstreq_r <= 1'b0;
      end
   end

   // ****************************************
   // Masking and priority
   // ****************************************
   assign req_w      = pend_r | lvl_w;
   assign mask_eff_w = {mask_r[`DSPIC_NSRC-1:1], 1'b1};
   assign elig_w     = req_w & mask_eff_w;
   assign sel_w      = dspic_first(elig_w);
   assign isr_top_w  = dspic_first(isr_r);

   // Nesting admits only strictly higher priority than the active routine
   assign allow_w = ctrl_r[`DSPIC_CTL_NEST] ? (sel_w < isr_top_w)
                                            : (isr_r == '0);
   assign req_nxt = !ack_i && (rstreq_r ||
                    (gie_r && !holdoff_r && (sel_w != `DSPIC_SRC_NONE) && allow_w));

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         req_r     <= 1'b0;
         rst_sel_r <= 1'b0;
         idx_r     <= `DSPIC_SRC_NONE;
         vec_r     <= `DSPIC_VEC_RST;
      end else begin
         req_r     <= req_nxt;
         rst_sel_r <= rstreq_r;
         idx_r     <= rstreq_r ? `DSPIC_SRC_NONE : sel_w;
         vec_r     <= rstreq_r ? `DSPIC_VEC_RST : dspic_vec_of(sel_w);
      end
   end

   // ****************************************
   // In-service tracking
   // ****************************************
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         isr_r <= '0;
      end else if (take_w && rst_sel_r) begin
         isr_r <= '0;
      end else begin
         isr_r <= (isr_r & ~((rti_i && isr_top_w != `DSPIC_SRC_NONE) ?
                  (dspic_src_t'(1) << isr_top_w) : '0)) | ackclr_w;
      end
   end

   // ****************************************
   // Global enable and mask-write holdoff
   // ****************************************
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         gie_r <= 1'b1;
      end else if (global_irq_off_instr_i) begin
         gie_r <= 1'b0;
      end else if (global_irq_on_instr_i) begin
         gie_r <= 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         holdoff_r <= 1'b0;
      end else begin
         holdoff_r <= bus_i.wr && (bus_i.addr == `DSPIC_OFF_MASK);
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mask_r <= `DSPIC_MASK_RST;
      end else if (bus_i.wr && bus_i.addr == `DSPIC_OFF_MASK) begin
         mask_r <= bus_i.wdata[`DSPIC_NSRC-1:0];
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl_r <= `DSPIC_CTRL_RST;
      end else if (bus_i.wr && bus_i.addr == `DSPIC_OFF_CTRL) begin
         ctrl_r <= bus_i.wdata[`DSPIC_CTL_W-1:0];
      end
   end

   // Unmapped and write-only addresses read as zero
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_r <= 32'h0000_0000;
      end else if (bus_i.rd) begin
         rdata_r <= 32'h0000_0000;
         unique case (bus_i.addr)
            `DSPIC_OFF_MASK: rdata_r[`DSPIC_NSRC-1:0] <= mask_eff_w;
            `DSPIC_OFF_CTRL: rdata_r[`DSPIC_CTL_W-1:0] <= ctrl_r;
            `DSPIC_OFF_STAT: begin
               rdata_r[`DSPIC_NSRC-1:0]                <= req_w;
               rdata_r[`DSPIC_STAT_ISR +: `DSPIC_NSRC] <= isr_r;
               rdata_r[`DSPIC_STAT_GIE]                <= gie_r;
               rdata_r[`DSPIC_STAT_OVF]                <= stk_ovf_r;
            end
            `DSPIC_OFF_VEC: rdata_r[19:0] <= {sp_r, vec_r};
            default: rdata_r <= 32'h0000_0000;
         endcase
      end
   end

   // ****************************************
   // Status stack
   // ****************************************
   // Shared with loops and calls; a push when full is dropped and flagged
   assign push_w = (take_w && !rst_sel_r) || stk_push_i;
   assign pop_w  = rti_i || stk_pop_i;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sp_r      <= 4'h0;
         stk_top_r <= 16'h0000;
         stk_ovf_r <= 1'b0;
      end else if (push_w) begin
         if (sp_r < `DSPIC_STK_DEPTH) begin
            sp_r      <= sp_r + 4'h1;
            stk_top_r <= status_i;
         end else begin
            stk_ovf_r <= 1'b1;
         end
      end else if (pop_w && sp_r != 4'h0) begin
         sp_r      <= sp_r - 4'h1;
         stk_top_r <= (sp_r > 4'h1) ? stk_mem[sp_r - 4'h2] : 16'h0000;
      end
   end

   always_ff @(posedge clk_i) begin
      if (push_w && sp_r < `DSPIC_STK_DEPTH) begin
         stk_mem[sp_r] <= status_i;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign rdata_o     = rdata_r;
   assign irq_req_o   = req_r;
   assign irq_vec_o   = vec_r;
   assign irq_src_o   = idx_r;
   assign stk_top_o   = stk_top_r;
   assign stk_full_o  = (sp_r == `DSPIC_STK_DEPTH);
   assign stk_empty_o = (sp_r == 4'h0);
   assign flag_in_o   = sync2_r.flag_in;
   assign flag_out_o  = ctrl_r[`DSPIC_CTL_FOUT];
   assign sp1_alt_o   = ctrl_r[`DSPIC_CTL_ALT];

   // ****************************************
   // Assertions
   // ****************************************
   pd_nomask_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (pend_r[0] && gie_r && !holdoff_r && isr_r == '0 && !rstreq_r && !ack_i)
      |=> (irq_req_o && irq_vec_o == `DSPIC_VEC_PD))
      else $error("power-down request not raised");

   prio_pick_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (irq_req_o && !rst_sel_r) |-> irq_vec_o == dspic_vec_of(dspic_first($past(elig_w))))
      else $error("vector is not the highest eligible source");

   mask_gate_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (irq_req_o && !rst_sel_r) |-> (irq_src_o == `DSPIC_SRC_PD || $past(mask_r[sel_w])))
      else $error("masked source requested");

   holdoff_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (bus_i.wr && bus_i.addr == `DSPIC_OFF_MASK && !rstreq_r) ##1 !rstreq_r
      |=> !irq_req_o)
      else $error("request during mask holdoff");

   gie_off_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (!gie_r && !rstreq_r) |=> !irq_req_o)
      else $error("request while globally disabled");

   gie_reset_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $rose(rst_n_i) |-> gie_r)
      else $error("global enable off after reset");

   no_nest_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (!ctrl_r[`DSPIC_CTL_NEST] && isr_r != '0 && !rstreq_r) |=> !irq_req_o)
      else $error("new routine started without nesting");

   edge_latch_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      fall_w.edge_n |=> pend_r[`DSPIC_SRC_EDGE])
      else $error("edge request not latched");

   stack_push_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (push_w && sp_r < `DSPIC_STK_DEPTH) |=> (sp_r == $past(sp_r) + 4'h1 &&
      stk_top_o == $past(status_i)))
      else $error("stack push lost");

   rst_vec_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (rstreq_r && !ack_i) |=> (irq_req_o && irq_vec_o == `DSPIC_VEC_RST))
      else $error("context reset not vectored to zero");

   nested_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      take_w && isr_r != '0);
   powerup_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      take_w && rst_sel_r);
   stk_full_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      stk_full_o && push_w);
   timer_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      take_w && idx_r == `DSPIC_SRC_TMR);

endmodule : dspic_ctrl

// *** tb/dspic_src_model.sv ***
module dspic_src_model
   import dspic_pkg::*;
(
   input  wire logic        clk_i,
   input  wire dspic_pins_t lvl_i,
   input  wire dspic_evt_t  fire_i,
   output dspic_pins_t      pins_o,
   output dspic_evt_t       evt_o
);
   timeunit 1ns;
   timeprecision 1ns;

   // Pins move only after an edge, as a real board source would seen from this clock
   always_ff @(posedge clk_i) begin
      pins_o <= lvl_i;
      evt_o  <= fire_i;
   end
endmodule : dspic_src_model

// *** tb/dspic_ctrl_tb.sv ***
module dspic_ctrl_tb
   import dspic_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_i   = 1'b0;
   logic        rst_n_i = 1'b0;
   logic [6:0]  ctl     = 7'h00;
   logic [15:0] stat    = 16'h0000;
   logic [15:0] vec, top;
   logic [31:0] rdata;
   logic [3:0]  src;
   logic        req, full, empty, fin, fout, alt;
   dspic_bus_t  bus     = '0;
   dspic_pins_t lvl     = 7'h7e;
   dspic_evt_t  fire    = 7'h00;
   dspic_pins_t pins;
   dspic_evt_t  evt;
   int          fail_count      = 0;
   int          samples_checked = 0;
   logic [15:0] vtab [11] = '{16'h002c, 16'h0004, 16'h0008, 16'h000c, 16'h0010, 16'h0014,
                              16'h0018, 16'h001c, 16'h0020, 16'h0024, 16'h0028};

   always #20 clk_i = ~clk_i;

   // Strobe bits: 0 ack, 1 return, 2 on, 3 off, 4 push, 5 pop, 6 power-up
   dspic_src_model u_src (.clk_i(clk_i), .lvl_i(lvl), .fire_i(fire), .pins_o(pins), .evt_o(evt));
   dspic_ctrl u_dut (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .bus_i(bus), .rdata_o(rdata), .pins_i(pins),
      .evt_i(evt), .powerup_i(ctl[6]), .powerup_context_reset_bit_i(1'b1), .ack_i(ctl[0]),
      .rti_i(ctl[1]), .global_irq_on_instr_i(ctl[2]), .global_irq_off_instr_i(ctl[3]),
      .stk_push_i(ctl[4]), .stk_pop_i(ctl[5]), .status_i(stat), .irq_req_o(req),
      .irq_vec_o(vec), .irq_src_o(src), .stk_top_o(top), .stk_full_o(full),
      .stk_empty_o(empty), .flag_in_o(fin), .flag_out_o(fout), .sp1_alt_o(alt)
   );

   // ****************************************
   // Tasks
   // ****************************************
   task automatic conclude();
      $display("mismatches %0d, checks %0d", fail_count, samples_checked);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : conclude

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_i);
      bus.wr <= 1'b0;
   endtask : wr

   // Read data appear in the cycle after the strobe and stay until the next read
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp,
                     input string what);
      @(posedge clk_i);
      bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clk_i);
      bus.rd <= 1'b0;
      #1;
      check(what, exp, rdata & m);
   endtask : rd

   task automatic pulse(input int b);
      @(posedge clk_i);
      ctl[b] <= 1'b1;
      @(posedge clk_i);
      ctl[b] <= 1'b0;
   endtask : pulse

   task automatic fire_evt(input dspic_evt_t e);
      @(posedge clk_i);
      fire <= e;
      @(posedge clk_i);
      fire <= 7'h00;
   endtask : fire_evt

   task automatic quiet(input int c);
      repeat (c) begin
         @(posedge clk_i);
         #1;
         check("idle request", 32'h0, 32'(req));
      end
   endtask : quiet

   // Waits for a request, checks it, accepts it and expects the line to drop
   task automatic take(input logic [15:0] v, input logic [3:0] s);
      int n = 0;
      do begin
         @(posedge clk_i);
         #1;
         n++;
      end while (req !== 1'b1 && n < 30);
      if (req !== 1'b1) begin
         fail_count++;
         conclude();
      end
      check("vector", 32'(v), 32'(vec));
      check("source", 32'(s), 32'(src));
      pulse(0);
      quiet(5);
   endtask : take

   // ****************************************
   // Sequence
   // ****************************************
   initial begin
      repeat (10) @(posedge clk_i);
      rst_n_i <= 1'b1;
      rd(8'h00, 32'hffffffff, 32'h1, "mask");
      rd(8'h0c, 32'h08000000, 32'h08000000, "global enable");
      rd(8'h08, 32'hffffffff, 32'h0, "force clear readback");
      rd(8'h40, 32'hffffffff, 32'h0, "unmapped");
      pulse(6);
      take(16'h0000, 4'hf);
      fire_evt(7'h01);
      take(16'h002c, 4'h0);
      pulse(1);
      @(posedge clk_i);
      lvl <= 7'h0e;
      wr(8'h00, 32'h7ff);
      wr(8'h08, 32'h7f0);
      for (int i = 1; i < 11; i++) begin
         take(vtab[i], i[3:0]);
         @(posedge clk_i);
         if (i < 4) lvl[7-i] <= 1'b1;
         quiet(5);
         pulse(1);
      end
      wr(8'h00, 32'h0);
      wr(8'h08, 32'h400);
      quiet(4);
      rd(8'h0c, 32'h7ff, 32'h400, "masked pending");
      wr(8'h00, 32'h480);
      @(posedge clk_i);
      #1;
      check("mask holdoff", 32'h0, 32'(req));
      take(16'h0028, 4'ha);
      wr(8'h04, 32'h8);
      wr(8'h08, 32'h80);
      take(16'h001c, 4'h7);
      wr(8'h08, 32'h400);
      quiet(4);
      pulse(1);
      quiet(4);
      pulse(1);
      take(16'h0028, 4'ha);
      pulse(1);
      pulse(3);
      rd(8'h0c, 32'h08000000, 32'h0, "global enable off");
      fire_evt(7'h01);
      quiet(4);
      pulse(2);
      take(16'h002c, 4'h0);
      pulse(1);
      wr(8'h04, 32'h1);
      wr(8'h00, 32'h0);
      @(posedge clk_i);
      lvl <= 7'h36;
      repeat (3) @(posedge clk_i);
      lvl <= 7'h7e;
      repeat (5) @(posedge clk_i);
      rd(8'h0c, 32'h7ff, 32'h42, "edge latches");
      wr(8'h08, 32'h00420000);
      rd(8'h0c, 32'h7ff, 32'h0, "cleared latches");
      wr(8'h04, 32'h30);
      wr(8'h00, 32'h200);
      @(posedge clk_i);
      lvl <= 7'h7b;
      take(16'h0024, 4'h9);
      check("alt and flag out", 32'h3, 32'({alt, fout}));
      check("flag in", 32'h1, 32'(fin));
      @(posedge clk_i);
      lvl <= 7'h7e;
      repeat (5) @(posedge clk_i);
      pulse(1);
      for (int i = 0; i < 12; i++) begin
         stat <= 16'(i);
         pulse(4);
      end
      #1;
      check("stack top", 32'hb, 32'(top));
      check("stack full", 32'h1, 32'(full));
      pulse(4);
      rd(8'h0c, 32'h10000000, 32'h10000000, "stack overflow");
      repeat (12) pulse(5);
      #1;
      check("stack empty", 32'h1, 32'(empty));
      conclude();
   end
endmodule : dspic_ctrl_tb
